// File: src/ccp_pkg.sv
// Shared types, register map and timing counts for the coil chopper.
// Assumes one 200 MHz system clock; all counts are in its cycles.
package ccp_pkg;

    // ***************************************************
    // Register map
    // ***************************************************
    localparam logic [7:0]  CTRL_ADR = 8'h00;
    localparam logic [7:0]  STAT_ADR = 8'h04;
    localparam int unsigned CFG_W    = 18;
    localparam logic [17:0] CTRL_RST = 18'h00000;
    localparam logic [7:0]  LFSR_SEED = 8'h5a;

    // ***************************************************
    // Timing counts
    // ***************************************************
    localparam logic [9:0]        SLOW_BASE = 10'h018;
    localparam logic [3:0]        DEC_LAST  = 4'hf;
    localparam logic signed [5:0] END_BIAS  = 6'sh03;
    localparam logic [5:0]        BLANK_0   = 6'h10;
    localparam logic [5:0]        BLANK_1   = 6'h18;
    localparam logic [5:0]        BLANK_2   = 6'h24;
    localparam logic [5:0]        BLANK_3   = 6'h36;

    // ***************************************************
    // Types
    // ***************************************************
    typedef enum logic [1:0] {
        PH_OFF  = 2'b00,
        PH_ON   = 2'b01,
        PH_FAST = 2'b10,
        PH_SLOW = 2'b11
    } ccp_phase_e;

    // Control word, msb first: bit 17 down to bit 0
    typedef struct packed {
        logic       fullstep;
        logic [1:0] blank_time_select;
        logic       chm;
        logic       rndtf;
        logic       dis_fd_cmp;
        logic       fast_decay_extra_bit;
        logic [3:0] hysteresis_end_field;
        logic [2:0] hysteresis_start_field;
        logic [3:0] off_time_setting;
    } ccp_cfg_s;

    typedef struct packed {
        logic above;
        logic below;
        logic neg;
    } ccp_sense_s;

    typedef struct packed {
        ccp_phase_e        ph;
        logic signed [5:0] hyst;
    } ccp_drive_s;

    typedef struct packed {
        ccp_phase_e        ph;
        logic              second;
        logic [9:0]        tmr;
        logic [5:0]        blank;
        logic signed [5:0] hyst;
        logic [3:0]        dec;
    } ccp_coil_s;

    typedef struct packed {
        ccp_coil_s [1:0] coil;
        logic [7:0]      lfsr;
    } ccp_state_s;

    typedef struct packed {
        ccp_cfg_s    cfg;
        logic        ack;
        logic [31:0] dat;
    } ccp_regs_s;

    // ***************************************************
    // Helpers
    // ***************************************************
    function automatic logic [5:0] blank_len(input logic [1:0] sel);
        logic [5:0] r;
        unique case (sel)
            2'd0: r = BLANK_0;
            2'd1: r = BLANK_1;
            2'd2: r = BLANK_2;
            2'd3: r = BLANK_3;
        endcase
        return r;
    endfunction

    function automatic logic [9:0] slow_len(input logic [3:0] off_t,
                                            input logic [2:0] rnd);
        return SLOW_BASE + {1'b0, off_t, 5'h00} + {7'h00, rnd};
    endfunction

    function automatic logic [9:0] fd_len(input ccp_cfg_s c);
        return {1'b0, c.fast_decay_extra_bit, c.hysteresis_start_field, 5'h00};
    endfunction

    function automatic logic signed [5:0] hyst_end(input logic [3:0] end_fld);
        return $signed({2'b00, end_fld}) - END_BIAS;
    endfunction

    function automatic logic signed [5:0] hyst_start(input logic [2:0] hs,
                                                     input logic [3:0] he);
        return hyst_end(he) + $signed({3'b000, hs}) + 6'sh01;
    endfunction

endpackage

// File: src/ccp_wb_regs.sv
// Wishbone classic slave holding the chopper control word.
// Assumes a master that holds each request until it sees ack.
`timescale 1ns/1ps
module ccp_wb_regs
    import ccp_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 wb_cyc_in,
    input  wire logic                 wb_stb_in,
    input  wire logic                 wb_we_in,
    input  wire logic [7:0]           wb_adr_in,
    input  wire logic [3:0]           wb_sel_in,
    input  wire logic [31:0]          wb_dat_in,
    input  wire ccp_pkg::ccp_drive_s [1:0] status_in,
    output      ccp_pkg::ccp_cfg_s    cfg_out,
    output      logic                 wb_ack_out,
    output      logic [31:0]          wb_dat_out
);
    import ccp_pkg::*;

    ccp_regs_s q;
    ccp_regs_s d;

    // ***************************************************
    // Access decode
    // ***************************************************
    // One wait state; ack gated by itself so it drops after one cycle
    always_comb begin
        logic [31:0] w;
        w     = {14'h0000, q.cfg};
        d     = q;
        d.ack = 1'b0;
        if (wb_cyc_in && wb_stb_in && !q.ack) begin
            d.ack = 1'b1;
            d.dat = 32'h00000000;
            if (wb_adr_in == CTRL_ADR) begin
                d.dat = w;
                if (wb_we_in) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_in[b]) begin
                            w[8*b +: 8] = wb_dat_in[8*b +: 8];
                        end
                    end
                    d.cfg = w[CFG_W-1:0];
                end
            end else if (wb_adr_in == STAT_ADR) begin
                d.dat = {16'h0000, status_in};
            end
        end
    end

    // Register the whole state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '{cfg: CTRL_RST, ack: 1'b0, dat: 32'h00000000};
        end else begin
            q <= d;
        end
    end

    assign cfg_out    = q.cfg;
    assign wb_ack_out = q.ack;
    assign wb_dat_out = q.dat;

endmodule

// File: src/ccp_chopper.sv
// Two-coil chopper phase sequencer with Wishbone control registers.
// Assumes comparator inputs synchronous to clk_in and bridge logic
// that decodes each coil's phase code into transistor gates.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

// Function
// - Working hysteresis drops by one step every 16 clocks during a cycle.
// - Each cycle loads start plus end, decrements until cycle end or end value.
// - End field is biased by three: 3 is zero, below negative, above positive.
// - Start field adds to end value and counts one more than its raw value.
// - Off-time mode: on phase ends on comparator, then a timed fast decay.
// - Mode 1 fast decay length comes from extra bit and start field.
// - Off-time mode reuses end field as a signed zero-crossing offset.
// - Fast decay may end early on negative current unless comparator disabled.
// - Random enable modulates slow decay length from a pseudo-random generator.
// - Full stepping forces the off-time chopper whatever the mode bit says.
// - Both coil choppers run independently with no cycle synchronisation.
// - Slow decay lasts 24 plus 32 times off time; zero freewheels.
// - Comparator masked for 16, 24, 36 or 54 clocks after switching.
// - Mode 0 cycles on, slow, fast, slow; mode 1 on, fast, slow.
module ccp_chopper
    import ccp_pkg::*;
(
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      wb_cyc_in,
    input  wire logic                      wb_stb_in,
    input  wire logic                      wb_we_in,
    input  wire logic [7:0]                wb_adr_in,
    input  wire logic [3:0]                wb_sel_in,
    input  wire logic [31:0]               wb_dat_in,
    input  wire ccp_pkg::ccp_sense_s [1:0] sense_in,
    output      logic                      wb_ack_out,
    output      logic [31:0]               wb_dat_out,
    output      ccp_pkg::ccp_drive_s [1:0] coil_out
);
    import ccp_pkg::*;

    ccp_state_s       q;
    ccp_state_s       d;
    ccp_cfg_s         cfg;
    logic             cmode;
    ccp_drive_s [1:0] drive;

    // ***************************************************
    // Register slave
    // ***************************************************
    ccp_wb_regs ccp_wb_regs_inst (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .wb_cyc_in  (wb_cyc_in),
        .wb_stb_in  (wb_stb_in),
        .wb_we_in   (wb_we_in),
        .wb_adr_in  (wb_adr_in),
        .wb_sel_in  (wb_sel_in),
        .wb_dat_in  (wb_dat_in),
        .status_in  (drive),
        .cfg_out    (cfg),
        .wb_ack_out (wb_ack_out),
        .wb_dat_out (wb_dat_out)
    );

    // ***************************************************
    // Mode select
    // ***************************************************
    // fullstep forces off-time
    assign cmode = cfg.chm | cfg.fullstep;

    // Switch phase: restart blanking and load the phase timer
    function automatic ccp_coil_s go(input ccp_coil_s c,
                                     input ccp_phase_e ph,
                                     input logic [9:0] tmr,
                                     input logic [1:0] bsel);
        ccp_coil_s r;
        r = c;
        r.ph = ph;
        r.tmr = tmr;
        r.blank = blank_len(bsel) - 6'h01;
        return r;
    endfunction

    // ***************************************************
    // Phase sequencers
    // ***************************************************
    // Each coil steps on its own state; only config and lfsr are shared
    always_comb begin
        ccp_coil_s  cs;
        ccp_coil_s  n;
        logic       open;
        logic [2:0] rnd;
        logic [9:0] slow_t;
        cs = '0;
        n = '0;
        open = 1'b0;
        d = q;
        d.lfsr = {q.lfsr[6:0], q.lfsr[7] ^ q.lfsr[5] ^ q.lfsr[4] ^ q.lfsr[3]};
        rnd = cfg.rndtf ? q.lfsr[2:0] : 3'h0;
        slow_t = slow_len(cfg.off_time_setting, rnd) - 10'h001;
        for (int c = 0; c < 2; c++) begin
            cs = q.coil[c];
            n = cs;
            open = (cs.blank == 6'h00);
            if (!open) begin
                n.blank = cs.blank - 6'h01;
            end
            if (cs.tmr != 10'h000) begin
                n.tmr = cs.tmr - 10'h001;
            end
            if (!cmode && cs.ph != PH_OFF) begin
                n.dec = cs.dec + 4'h1;
                if (cs.dec == DEC_LAST &&
                    cs.hyst > hyst_end(cfg.hysteresis_end_field)) begin
                    n.hyst = cs.hyst - 6'sh01;
                end
            end
            if (cfg.off_time_setting == 4'h0) begin
                n.ph = PH_OFF;
            end else begin
                unique case (cs.ph)
                    PH_OFF: begin
                        n = go(n, PH_ON, 10'h000, cfg.blank_time_select);
                    end
                    PH_ON: begin
                        if (open && sense_in[c].above) begin
                            n.second = cmode;
                            // fast decay length zero skips it
                            if (cmode && fd_len(cfg) != 10'h000) begin
                                n = go(n, PH_FAST, fd_len(cfg) - 10'h001,
                                       cfg.blank_time_select);
                            end else begin
                                n = go(n, PH_SLOW, slow_t, cfg.blank_time_select);
                            end
                        end
                    end
                    PH_FAST: begin
                        if (cmode) begin
                            if (cs.tmr == 10'h000 ||
                                (open && !cfg.dis_fd_cmp && sense_in[c].neg)) begin
                                n = go(n, PH_SLOW, slow_t, cfg.blank_time_select);
                            end
                        end else if (open && sense_in[c].below) begin
                            n = go(n, PH_SLOW, slow_t, cfg.blank_time_select);
                            n.second = 1'b1;
                        end
                    end
                    PH_SLOW: begin
                        if (cs.tmr == 10'h000) begin
                            // first slow decay leads to fast decay
                            if (!cmode && !cs.second) begin
                                n = go(n, PH_FAST, 10'h000, cfg.blank_time_select);
                            end else begin
                                n = go(n, PH_ON, 10'h000, cfg.blank_time_select);
                            end
                        end
                    end
                endcase
                if (n.ph == PH_ON && cs.ph != PH_ON) begin
                    n.dec = 4'h0;
                    n.second = 1'b0;
                    n.hyst = cmode ? hyst_end(cfg.hysteresis_end_field)
                                   : hyst_start(cfg.hysteresis_start_field,
                                                cfg.hysteresis_end_field);
                end
            end
            d.coil[c] = n;
        end
    end

    // Register the whole state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '{coil: '0, lfsr: LFSR_SEED};
        end else begin
            q <= d;
        end
    end

    // ***************************************************
    // Outputs
    // ***************************************************
    // Phase and hysteresis straight from the state flops
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            drive[c].ph = q.coil[c].ph;
            drive[c].hyst = q.coil[c].hyst;
        end
    end
    assign coil_out = drive;

    // ***************************************************
    // Checks
    // ***************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Generator never locks up at zero
    a_lfsr_live: assert property (q.lfsr != 8'h00)
        else $error("random generator reached zero");

    for (genvar c = 0; c < 2; c++) begin : g_chk
        a_off_freewheel: assert property (
            cfg.off_time_setting == 4'h0 |=> q.coil[c].ph == PH_OFF)
            else $error("zero off time did not freewheel");

        a_blank_hold: assert property (
            (q.coil[c].ph == PH_ON && q.coil[c].blank != 6'h00 &&
             cfg.off_time_setting != 4'h0) |=> q.coil[c].ph == PH_ON)
            else $error("on phase left during blanking");

        a_blank_load: assert property (
            ($changed(q.coil[c].ph) && q.coil[c].ph != PH_OFF) |->
            q.coil[c].blank == blank_len($past(cfg.blank_time_select)) - 6'h01)
            else $error("blank time not loaded on switch");

        a_hyst_step: assert property (
            (!$changed(q.coil[c].ph) && $changed(q.coil[c].hyst)) |->
            (q.coil[c].hyst == $past(q.coil[c].hyst) - 6'sh01 &&
             $past(q.coil[c].dec) == DEC_LAST))
            else $error("hysteresis step wrong");

        a_hyst_load: assert property (
            ($changed(q.coil[c].ph) && q.coil[c].ph == PH_ON) |->
            q.coil[c].hyst == ($past(cmode) ?
                hyst_end($past(cfg.hysteresis_end_field)) :
                hyst_start($past(cfg.hysteresis_start_field),
                           $past(cfg.hysteresis_end_field))))
            else $error("cycle start hysteresis wrong");

        a_slow_len: assert property (
            ($changed(q.coil[c].ph) && q.coil[c].ph == PH_SLOW &&
             !$past(cfg.rndtf)) |->
            q.coil[c].tmr == slow_len($past(cfg.off_time_setting), 3'h0) - 10'h001)
            else $error("slow decay length wrong");

        a_fd_neg_end: assert property (
            (cmode && q.coil[c].ph == PH_FAST && q.coil[c].blank == 6'h00 &&
             !cfg.dis_fd_cmp && sense_in[c].neg && cfg.off_time_setting != 4'h0)
            |=> q.coil[c].ph == PH_SLOW)
            else $error("fast decay ignored negative comparator");

        a_fd_hyst_end: assert property (
            (!cmode && q.coil[c].ph == PH_FAST && q.coil[c].blank == 6'h00 &&
             sense_in[c].below && cfg.off_time_setting != 4'h0)
            |=> (q.coil[c].ph == PH_SLOW && q.coil[c].tmr != 10'h000))
            else $error("hysteresis fast decay did not end");

        a_spread_order: assert property (
            (!cmode && q.coil[c].ph == PH_ON && cfg.off_time_setting != 4'h0)
            |=> q.coil[c].ph inside {PH_ON, PH_SLOW})
            else $error("mode 0 on phase went to wrong phase");

        a_const_order: assert property (
            (cmode && q.coil[c].ph == PH_ON && fd_len(cfg) != 10'h000 &&
             cfg.off_time_setting != 4'h0)
            |=> q.coil[c].ph inside {PH_ON, PH_FAST})
            else $error("off-time on phase skipped fast decay");
    end

endmodule

// File: tb/ccp_coil_model.sv
// Behavioural bridge and current comparator for one coil.
// Assumes the chopper samples sense levels on the rising edge of clk_in.
`timescale 1ns/1ps
module ccp_coil_model
    import ccp_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire ccp_pkg::ccp_drive_s  drive_in,
    input  wire logic [7:0]           on_dly_in,
    input  wire logic [7:0]           fd_dly_in,
    input  wire logic [7:0]           neg_dly_in,
    output      ccp_pkg::ccp_sense_s  sense_out
);
    // ***************************************************
    // Current ramp stand-in
    // ***************************************************
    ccp_phase_e  last_q  = PH_OFF;
    logic [9:0]  cnt_q   = 10'h000;
    ccp_sense_s  sense_q = '0;

    assign sense_out = sense_q;

    // Time in phase stands in for coil current; 8'hff on neg_dly_in means never trips
    always @(posedge clk_in) begin
        last_q <= drive_in.ph;
        cnt_q  <= (drive_in.ph != last_q) ? 10'h000 : cnt_q + {9'h000, cnt_q != 10'h3ff};
        sense_q.above <= drive_in.ph == PH_ON && cnt_q >= {2'b00, on_dly_in};
        sense_q.below <= drive_in.ph == PH_FAST && cnt_q >= {2'b00, fd_dly_in};
        sense_q.neg   <= drive_in.ph == PH_FAST && neg_dly_in != 8'hff
                         && cnt_q >= {2'b00, neg_dly_in};
    end
endmodule

// File: tb/coil_chopper_phase_control_tb.sv
// Self-checking bench for the two-coil chopper sequencer.
// Assumes Wishbone classic access and one coil model on each coil.
`timescale 1ns/1ps
module coil_chopper_phase_control_tb;
    import ccp_pkg::*;
    // ***************************************************
    // Signals and instances
    // ***************************************************
    logic             clk_in     = 1'b0;
    logic             rst_n_in   = 1'b0;
    logic             wb_cyc_in  = 1'b0;
    logic             wb_stb_in  = 1'b0;
    logic             wb_we_in   = 1'b0;
    logic [7:0]       wb_adr_in  = 8'h00;
    logic [3:0]       wb_sel_in  = 4'h0;
    logic [31:0]      wb_dat_in  = 32'h0;
    wire ccp_sense_s [1:0] sense_in;
    logic             wb_ack_out;
    logic [31:0]      wb_dat_out;
    ccp_drive_s [1:0] coil_out;
    logic [7:0]       on_dly [2] = '{8'h14, 8'h3c};
    logic [7:0]       fd_dly     = 8'h1e;
    logic [7:0]       neg_dly    = 8'hff;
    int               err_count  = 0;
    int               check_count = 0;
    logic [5:0]       hprev      = 6'h00;
    int               gap        = 0;
    int               dec_gap    = 0;

    ccp_chopper ccp_chopper_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .sense_in(sense_in),
        .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .coil_out(coil_out));

    // Coil B gets a slower ramp so the two choppers drift apart
    for (genvar g = 0; g < 2; g++) begin : g_coil
        ccp_coil_model ccp_coil_model_inst (
            .clk_in(clk_in), .drive_in(coil_out[g]), .on_dly_in(on_dly[g]),
            .fd_dly_in(fd_dly), .neg_dly_in(neg_dly), .sense_out(sense_in[g]));
    end

    // Clock, reset and spacing of hysteresis decrements on coil A
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
    end
    always @(posedge clk_in) begin
        hprev <= coil_out[0].hyst;
        if (coil_out[0].hyst == hprev - 6'h01) begin
            dec_gap <= gap;
            gap     <= 1;
        end else if (coil_out[0].hyst != hprev) begin
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
    end

    // ***************************************************
    // Tasks
    // ***************************************************
    task automatic complete_run();
        $display("Mismatches %0d of %0d checks", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    // Range compare for lengths that carry a cycle of sensing latency
    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask

    // Classic single cycle; the request stands until ack is seen
    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] w, output logic [31:0] r);
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= a;
        wb_sel_in <= s;
        wb_dat_in <= w;
        // No cycle count assumed; only the watchdog ends a lost ack
        do begin
            @(posedge clk_in);
        end while (wb_ack_out !== 1'b1);
        r = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask

    // Flags are {fullstep, blank select, mode, random, fd cmp off, extra bit}
    function automatic logic [31:0] cfg(input logic [3:0] off_t, input logic [2:0] hs,
                                        input logic [3:0] he, input logic [6:0] fl);
        ccp_cfg_s c;
        c = {fl, he, hs, off_t};
        return {14'h0000, c};
    endfunction

    // Freewheel first so every scenario sees a fresh OFF to ON start
    task automatic start(input logic [31:0] c);
        logic [31:0] d;
        wb(1'b1, CTRL_ADR, 4'hf, 32'h0, d);
        repeat (4) @(posedge clk_in);
        chk(coil_out[0].ph, PH_OFF);
        wb(1'b1, CTRL_ADR, 4'hf, c, d);
    endtask

    // Length of the next segment of phase p on coil A; a hang is the watchdog's
    task automatic seg(input ccp_phase_e p, output int len, output ccp_phase_e nxt,
                       output logic [5:0] h);
        len = 0;
        while (coil_out[0].ph !== p) begin
            @(posedge clk_in);
        end
        h = coil_out[0].hyst;
        while (coil_out[0].ph === p) begin
            @(posedge clk_in);
            len++;
        end
        nxt = coil_out[0].ph;
    endtask

    // ***************************************************
    // Tests
    // ***************************************************
    initial begin
        #(5 * 40000);
        err_count++;
        complete_run();
    end

    initial begin
        logic [31:0] d;
        int          l;
        int          l0;
        logic        diff;
        ccp_phase_e  n;
        logic [5:0]  h;
        wait (rst_n_in === 1'b1);
        // Reset value, unmapped place, read-only status, byte enables
        wb(1'b0, CTRL_ADR, 4'hf, 32'h0, d);
        chk(d, 32'h0);
        wb(1'b1, 8'h08, 4'hf, 32'hffffffff, d);
        wb(1'b0, 8'h08, 4'hf, 32'h0, d);
        chk(d, 32'h0);
        wb(1'b1, STAT_ADR, 4'hf, 32'hffffffff, d);
        wb(1'b0, STAT_ADR, 4'hf, 32'h0, d);
        chk(d, 32'h0);
        wb(1'b1, CTRL_ADR, 4'h2, 32'hffffffff, d);
        wb(1'b0, CTRL_ADR, 4'hf, 32'h0, d);
        chk(d, 32'h0000ff00);
        // Mode 0: start 2+2+1=5 over end 5-3=2, slow 24+32*2
        start(cfg(4'h2, 3'h2, 4'h5, 7'b0_00_0_0_0_0));
        seg(PH_ON, l, n, h);
        chk(h, 6'h05);
        chk(n, PH_SLOW);
        // Coil B ramps slower and is still in its on phase
        chk(coil_out[1].ph, PH_ON);
        seg(PH_SLOW, l, n, h);
        chk(l, 88);
        chk(n, PH_FAST);
        seg(PH_FAST, l, n, h);
        chk(h, 6'h02);
        rng(l, 30, 33);
        chk(n, PH_SLOW);
        // Status shows coil A in slow decay at the floored hysteresis
        wb(1'b0, STAT_ADR, 4'hf, 32'h0, d);
        chk(d[7:0], {PH_SLOW, 6'h02});
        seg(PH_SLOW, l, n, h);
        chk(n, PH_ON);
        chk(dec_gap, 16);
        seg(PH_ON, l, n, h);
        chk(h, 6'h05);
        // Longest blank masks instant comparator trips
        on_dly[0] <= 8'h00;
        fd_dly    <= 8'h00;
        start(cfg(4'h2, 3'h2, 4'h5, 7'b0_11_0_0_0_0));
        seg(PH_ON, l, n, h);
        rng(l, 54, 56);
        seg(PH_FAST, l, n, h);
        rng(l, 54, 56);
        // Off-time: fast 32*{1,001}=288, below and neg ignored
        on_dly[0] <= 8'h14;
        neg_dly   <= 8'h00;
        start(cfg(4'h2, 3'h1, 4'h6, 7'b0_00_1_0_1_1));
        seg(PH_ON, l, n, h);
        chk(h, 6'h03);
        rng(l, 20, 24);
        chk(n, PH_FAST);
        seg(PH_FAST, l, n, h);
        chk(l, 288);
        chk(n, PH_SLOW);
        seg(PH_SLOW, l, n, h);
        chk(l, 88);
        chk(n, PH_ON);
        // Comparator ends fast decay once blanking is over
        start(cfg(4'h2, 3'h1, 4'h6, 7'b0_00_1_0_0_1));
        seg(PH_FAST, l, n, h);
        rng(l, 16, 18);
        // Zero fast decay setting gives slow decay only
        start(cfg(4'h2, 3'h0, 4'h6, 7'b0_00_1_0_1_0));
        seg(PH_ON, l, n, h);
        chk(n, PH_SLOW);
        // Full stepping forces the off-time chopper over mode 0
        start(cfg(4'h2, 3'h1, 4'h6, 7'b1_00_0_0_1_0));
        seg(PH_ON, l, n, h);
        chk(n, PH_FAST);
        seg(PH_FAST, l, n, h);
        chk(l, 32);
        // Random off time stays within 88..95 and varies
        start(cfg(4'h2, 3'h1, 4'h6, 7'b0_00_1_1_1_0));
        diff = 1'b0;
        seg(PH_SLOW, l0, n, h);
        rng(l0, 88, 95);
        for (int i = 0; i < 6; i++) begin
            seg(PH_SLOW, l, n, h);
            rng(l, 88, 95);
            if (l != l0) diff = 1'b1;
        end
        chk(diff, 1'b1);
        start(32'h0);
        repeat (4) @(posedge clk_in);
        chk(coil_out[0].ph, PH_OFF);
        complete_run();
    end
endmodule
